// ### logic/evpw_pkg.sv
package evpw_pkg;
   localparam logic [15:0] VEC_RESET_MAIN  = 16'hfffe;
   localparam logic [15:0] VEC_RESET_CLOCK = 16'hfffc;
   localparam logic [15:0] VEC_RESET_WDOG  = 16'hfffa;
   localparam logic [7:0]  OFS_TRAP        = 8'hf8;
   localparam logic [7:0]  OFS_SWTRAP      = 8'hf6;
   localparam logic [7:0]  OFS_XREQ        = 8'hf4;
   localparam logic [7:0]  OFS_LEVELI      = 8'hf2;
   localparam logic [7:0]  OFS_PERIPH_TOP  = 8'hf0;
   localparam logic [7:0]  OFS_PERIPH_LOW  = 8'h82;
   localparam logic [7:0]  OFS_SPURIOUS    = 8'h80;
   localparam logic [7:0]  BASE_RESET      = 8'hff;
   localparam logic [7:0]  BASE_DEBUG      = 8'hff;
   localparam logic [7:0]  BASE_LOW_BYTE   = 8'h00;
   localparam int          NUM_PERIPH_MAX  = 56;
   typedef enum logic [1:0] {EVPW_IDLE, EVPW_HOLD} evpw_state_t;
endpackage

// ### logic/evpw_periph_prio.sv
`timescale 1ns/1ps
// picks the highest-numbered pending peripheral request; index 0 is vector 0x82
module evpw_periph_prio #(
   parameter int NUM = 56
) (
   input  wire logic [NUM-1:0] req,
   output logic                any,
   output logic [7:0]          lowByte
);
   import evpw_pkg::*;
   always_comb begin
      any = 1'b0;
      lowByte = OFS_SPURIOUS;
      // ascending scan so the larger low byte wins
      for (int i = 0; i < NUM; i++) begin
         if (req[i]) begin
            any = 1'b1;
            lowByte = OFS_PERIPH_LOW + 8'(2 * i);
         end
      end
   end
endmodule // evpw_periph_prio

// ### logic/evpw_vector_unit.sv
`timescale 1ns/1ps
// Function
// - vector supplied only on core request, highest pending source wins
// - three resets outrank everything at 0xfffe, 0xfffc, 0xfffa
// - opcode trap at base+0xf8, then software trap at base+0xf6
// - x request at base+0xf4 below software trap, above I-maskable sources
// - level-I pin or die-link request at base+0xf2, top I-maskable
// - peripheral sources base+0xf0 down to 0x82, larger low byte wins
// - x source is x pin, or die-link error when initiator present
// - 0xf2 source is level-I pin, or die-link request when present
// - I-maskable routine preempted only by non-I requests until mask cleared
// - enabled I-maskable requests wake core; I mask blocks them
// - stop wake-up only from asynchronously asserted requests
// - x request wakes core regardless of x mask
// - x wake with x mask set enters no routine, resumes next instruction
// - no pending request on vector fetch gives spurious base+0x80
// - vector base is base register upper byte, 0x00 lower byte
// - base register resets to 0xff; debug active forces 0xff
module evpw_vector_unit #(
   parameter int NUM_PERIPH    = 56,
   parameter bit HAS_DIE_LINK  = 1'b0
) (
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   input  wire logic                  resetMain,
   input  wire logic                  resetClock,
   input  wire logic                  resetWdog,
   input  wire logic                  trapReq,
   input  wire logic                  softwareTrapReq,
   input  wire logic                  xLevelPinRequest,
   input  wire logic                  dieLinkErrorReq,
   input  wire logic                  levelIPinRequest,
   input  wire logic                  dieLinkReq,
   input  wire logic [NUM_PERIPH-1:0] periphReq,
   input  wire logic                  maskI,
   input  wire logic                  maskX,
   input  wire logic                  debugActive,
   input  wire logic                  baseWrite,
   input  wire logic [7:0]            baseWriteData,
   input  wire logic                  vectorRequest,
   input  wire logic                  vectorTaken,
   output logic [15:0]                vectorAddr,
   output logic                       vectorValid,
   output logic [7:0]                 vectorBaseRegister,
   output logic                       wakeRequest,
   output logic                       wakeSkipRoutine
);
   import evpw_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   logic       xSrc;
   logic       iTopSrc;
   logic       periphAny;
   logic [7:0] periphLow;
   logic       iPending;
   logic [7:0] upperByte;
   logic [15:0] winner;
   assign xSrc    = HAS_DIE_LINK ? dieLinkErrorReq : xLevelPinRequest;
   assign iTopSrc = HAS_DIE_LINK ? dieLinkReq : levelIPinRequest;
   evpw_periph_prio #(.NUM(NUM_PERIPH)) periphPrio (
      .req     (periphReq),
      .any     (periphAny),
      .lowByte (periphLow)
   );
   // I mask gates all I-level sources, so nested I routines wait
   assign iPending  = ~maskI & (iTopSrc | periphAny);
   assign upperByte = debugActive ? BASE_DEBUG : vectorBaseRegister;
   always_comb begin
      // combinational over the inputs at the request cycle
      if (resetMain)                winner = VEC_RESET_MAIN;
      else if (resetClock)          winner = VEC_RESET_CLOCK;
      else if (resetWdog)           winner = VEC_RESET_WDOG;
      else if (trapReq)             winner = {upperByte, OFS_TRAP};
      else if (softwareTrapReq)     winner = {upperByte, OFS_SWTRAP};
      else if (xSrc & ~maskX)       winner = {upperByte, OFS_XREQ};
      else if (~maskI & iTopSrc)    winner = {upperByte, OFS_LEVELI};
      else if (~maskI & periphAny)  winner = {upperByte, periphLow};
      else                          winner = {upperByte, OFS_SPURIOUS};
   end
   ////////////////////////////////////////////////////////////////////////////
   evpw_state_t state;
   evpw_state_t next_state;
   logic [15:0] next_vectorAddr;
   logic [7:0]  next_vectorBaseRegister;
   always_comb begin
      next_state = state;
      next_vectorAddr = vectorAddr;
      next_vectorBaseRegister = baseWrite ? baseWriteData : vectorBaseRegister;
      unique case (state)
         EVPW_IDLE: begin
            if (vectorRequest) begin
               next_vectorAddr = winner;
               next_state = EVPW_HOLD;
            end
         end
         EVPW_HOLD: begin
            // latched so a late-arriving source cannot tear the read
            if (vectorTaken) next_state = EVPW_IDLE;
         end
         default: next_state = EVPW_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state <= EVPW_IDLE;
         vectorAddr <= VEC_RESET_MAIN;
         vectorBaseRegister <= BASE_RESET;
      end else begin
         state <= next_state;
         vectorAddr <= next_vectorAddr;
         vectorBaseRegister <= next_vectorBaseRegister;
      end
   end
   assign vectorValid = (state == EVPW_HOLD);
   ////////////////////////////////////////////////////////////////////////////
   // wake path is pure gating, no clock needed, so it works in stop
   assign wakeRequest = xSrc | iPending | trapReq | softwareTrapReq;
   // x mask set: core resumes after the stop or wait instruction
   assign wakeSkipRoutine = xSrc & maskX & ~iPending;
   ////////////////////////////////////////////////////////////////////////////
   // helpers for the checks below; a fetch is only taken from idle
   logic fetchTaken;
   logic noReset;
   logic noTrap;
   logic xVectored;
   assign fetchTaken = (state == EVPW_IDLE) && vectorRequest;
   assign noReset    = !resetMain && !resetClock && !resetWdog;
   assign noTrap     = noReset && !trapReq && !softwareTrapReq;
   // x is vectored only while its mask is clear; masked it only wakes
   assign xVectored  = xSrc && !maskX;
   ////////////////////////////////////////////////////////////////////////////
   // one check per rung of the ladder, each with every higher rung quiet
   reset_prio_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && resetMain |=> vectorAddr == 16'hfffe)
      else $error("main reset vector wrong");
   clock_prio_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && !resetMain && resetClock |=> vectorAddr == 16'hfffc)
      else $error("clock monitor reset vector wrong");
   wdog_prio_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && !resetMain && !resetClock && resetWdog |=> vectorAddr == 16'hfffa)
      else $error("watchdog vector wrong");
   trap_vec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && noReset && trapReq |=> vectorAddr[7:0] == 8'hf8)
      else $error("trap vector wrong");
   swtrap_vec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && noReset && !trapReq && softwareTrapReq |=> vectorAddr[7:0] == 8'hf6)
      else $error("software trap vector wrong");
   xreq_vec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && noTrap && xVectored |=> vectorAddr[7:0] == 8'hf4)
      else $error("x request vector wrong");
   xmask_novec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && noTrap && xSrc && maskX |=> vectorAddr[7:0] != 8'hf4)
      else $error("masked x request was vectored");
   leveli_vec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && noTrap && !xVectored && !maskI && iTopSrc
      |=> vectorAddr[7:0] == 8'hf2)
      else $error("level-I vector wrong");
   periph_vec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && noTrap && !xVectored && !maskI && !iTopSrc && periphAny
      |=> vectorAddr[7:0] == $past(periphLow) && !vectorAddr[0])
      else $error("peripheral vector wrong");
   spurious_vec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && noTrap && !xVectored && !iPending |=> vectorAddr[7:0] == 8'h80)
      else $error("spurious vector wrong");
   // vector base, reset state and debug override
   base_fmt_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && noReset && !debugActive
      |=> vectorAddr[15:8] == $past(vectorBaseRegister))
      else $error("vector base wrong");
   debug_base_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken && debugActive |=> vectorAddr[15:8] == 8'hff)
      else $error("debug base not forced");
   base_load_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      baseWrite |=> vectorBaseRegister == $past(baseWriteData))
      else $error("vector base not loaded");
   base_reset_a: assert property (@(posedge ref_clk)
      !nrst |=> vectorBaseRegister == 8'hff && !vectorValid)
      else $error("reset state wrong");
   // handshake with the core; the held vector must not tear
   // a request seen while holding is simply ignored
   answer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetchTaken |=> vectorValid)
      else $error("vector not presented");
   quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !vectorValid && !vectorRequest |=> !vectorValid)
      else $error("vector without request");
   hold_stable_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      vectorValid && !vectorTaken |=> vectorValid && $stable(vectorAddr))
      else $error("vector not held");
   release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      vectorValid && vectorTaken |=> !vectorValid)
      else $error("vector not released");
   // wake path is level gating only, it must not depend on a clock edge
   imask_wake_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      maskI && !xSrc && !trapReq && !softwareTrapReq |-> !wakeRequest)
      else $error("masked I woke core");
   iwake_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !maskI && (iTopSrc || periphAny) |-> wakeRequest)
      else $error("enabled I request failed to wake");
   idle_wake_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !xSrc && !iPending && !trapReq && !softwareTrapReq |-> !wakeRequest)
      else $error("wake without a request");
   xwake_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      xSrc |-> wakeRequest)
      else $error("x request failed to wake");
   xskip_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      wakeSkipRoutine |-> xSrc && maskX && !iPending)
      else $error("routine skip without masked x wake");
   ////////////////////////////////////////////////////////////////////////////
   // scenarios worth seeing once
   fetch_c: cover property (@(posedge ref_clk) disable iff (!nrst)
      vectorRequest ##1 vectorValid ##[1:4] vectorTaken);
   spur_c: cover property (@(posedge ref_clk) disable iff (!nrst)
      vectorValid && vectorAddr[7:0] == 8'h80);
   xskip_c: cover property (@(posedge ref_clk) disable iff (!nrst) wakeSkipRoutine);
   periph_c: cover property (@(posedge ref_clk) disable iff (!nrst)
      vectorValid && vectorAddr[7:0] == 8'h82);
   xvec_c: cover property (@(posedge ref_clk) disable iff (!nrst)
      vectorValid && vectorAddr[7:0] == 8'hf4);
endmodule // evpw_vector_unit

// ### testbench/evpw_core_model.sv
`timescale 1ns/1ps
module evpw_core_model (
   input  wire logic        ref_clk,
   input  wire logic        vectorValid,
   input  wire logic [15:0] vectorAddr,
   output logic             vectorRequest,
   output logic             vectorTaken
);
   initial begin
      vectorRequest = 1'b0;
      vectorTaken   = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // stall keeps the answer waiting, so a vector that drifts shows up
   task automatic fetch(input int stall, output logic [15:0] vec, output bit late);
      int n;
      n = 0;
      @(posedge ref_clk);
      #1 vectorRequest = 1'b1;
      @(posedge ref_clk);
      #1 vectorRequest = 1'b0;
      while (vectorValid !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1 n++;
      end
      late = (n >= 20);
      repeat (stall) begin
         @(posedge ref_clk);
         #1;
      end
      vec = vectorAddr;
      vectorTaken = 1'b1;
      @(posedge ref_clk);
      #1 vectorTaken = 1'b0;
   endtask
endmodule // evpw_core_model

// ### testbench/exception_vector_priority_wake_bench.sv
`timescale 1ns/1ps
module exception_vector_priority_wake_bench;
   import evpw_pkg::*;
   logic        ref_clk, nrst, maskI, maskX, debugActive, baseWrite, dieLinkErr, dieLink;
   logic [6:0]  src;
   logic [55:0] periphReq;
   logic [7:0]  baseWriteData, vectorBaseRegister;
   logic        vectorRequest, vectorTaken, vectorValid, wakeRequest, wakeSkipRoutine;
   logic [15:0] vectorAddr, vec;
   int          miscompares, checkCount;
   bit          late;
   logic [15:0] ladder [0:6] = '{16'hfff2, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffa,
                                 16'hfffc, 16'hfffe};
   evpw_vector_unit #(.NUM_PERIPH(56), .HAS_DIE_LINK(1'b0)) dut (
      .ref_clk, .nrst, .resetMain(src[6]), .resetClock(src[5]), .resetWdog(src[4]),
      .trapReq(src[3]), .softwareTrapReq(src[2]), .xLevelPinRequest(src[1]),
      .levelIPinRequest(src[0]), .dieLinkErrorReq(dieLinkErr), .dieLinkReq(dieLink),
      .periphReq, .maskI, .maskX, .debugActive, .baseWrite, .baseWriteData,
      .vectorRequest, .vectorTaken, .vectorAddr, .vectorValid, .vectorBaseRegister,
      .wakeRequest, .wakeSkipRoutine);
   evpw_core_model core (.ref_clk, .vectorValid, .vectorAddr, .vectorRequest, .vectorTaken);
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic get(input int stall, input logic [15:0] exp);
      core.fetch(stall, vec, late);
      if (late) begin
         miscompares++;
         tally_and_finish();
      end
      check(vec, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // drop the top source each round so every rung wins once
   task automatic ladder_test();
      periphReq = '1;
      for (int i = 6; i >= 0; i--) begin
         src = 7'h7f >> (6 - i);
         get(0, ladder[i]);
      end
      src = 7'h00;
      get(0, 16'hfff0);
      periphReq = 56'h3;
      get(3, 16'hff84);
      periphReq = '0;
      dieLinkErr = 1'b1;
      dieLink = 1'b1;
      get(0, 16'hff80);
      dieLinkErr = 1'b0;
      dieLink = 1'b0;
   endtask
   task automatic mask_test();
      maskI = 1'b1;
      periphReq = 56'h1;
      #1 check({15'h0, wakeRequest}, 16'h0);
      get(0, 16'hff80);
      maskI = 1'b0;
      #1 check({15'h0, wakeRequest}, 16'h1);
      get(0, 16'hff82);
      periphReq = '0;
      maskX = 1'b1;
      src = 7'h02; // held through the fetch
      #1 check({14'h0, wakeRequest, wakeSkipRoutine}, 16'h3);
      get(0, 16'hff80);
      maskX = 1'b0;
      maskI = 1'b1;
      get(0, 16'hfff4);
      src = 7'h00;
      maskI = 1'b0;
      #1 check({15'h0, wakeRequest}, 16'h0);
   endtask
   task automatic base_test();
      @(posedge ref_clk);
      #1 baseWrite = 1'b1;
      baseWriteData = 8'h12; // table moved away from default
      @(posedge ref_clk);
      #1 baseWrite = 1'b0;
      check({8'h0, vectorBaseRegister}, 16'h0012);
      src = 7'h01;
      get(0, 16'h12f2);
      src = 7'h40;
      get(0, 16'hfffe);
      src = 7'h01;
      debugActive = 1'b1;
      get(0, 16'hfff2);
      debugActive = 1'b0;
      src = 7'h00;
      nrst = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 nrst = 1'b1;
      check({7'h0, vectorValid, vectorBaseRegister}, 16'h00ff);
      src = 7'h01;
      get(0, 16'hfff2);
      src = 7'h00;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {nrst, maskI, maskX, debugActive, baseWrite, dieLinkErr, dieLink} = '0;
      {src, periphReq, baseWriteData} = '0;
      {miscompares, checkCount} = '0;
      repeat (3) @(posedge ref_clk);
      #1 nrst = 1'b1;
      check({7'h0, vectorValid, vectorBaseRegister}, 16'h00ff);
      ladder_test();
      mask_test();
      base_test();
      tally_and_finish();
   end
endmodule // exception_vector_priority_wake_bench
